// File: src/link_selection_timers.sv
module link_selection_timers
  import link_timers_pkg::*;
#(
  parameter int TICK_CYCLES_P = link_timers_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Message framer events
  input wire logic tx_msg_done,
  input wire logic tx_msg_sel,
  input wire logic rx_msg_done,
  input wire logic rx_msg_valid,
  input wire logic rx_msg_sel,
  input wire logic [7:0] rx_msg_addr,
  input wire logic ack_rx,
  input wire logic remote_carrier,
  // Link control
  output logic tx_permit,
  output logic force_sel,
  output logic recover,
  output logic babble_resp,
  output logic [7:0] babble_code,
  output logic [7:0] babble_addr,
  output logic [15:0] sync_count,
  // Interrupt
  output logic irq
);
  import link_timers_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES_P);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  typedef struct packed {
    mode_t mode;
    logic speed_high;
    logic trib;
    logic [15:0] sel_period;
    logic [15:0] bab_period;
    logic [7:0] max_tx;
    logic [15:0] sync_set;
    logic sync_wr;
    logic [15:0] sync_cnt;
    logic [15:0] rate_kbps;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    link_t link;
    logic [15:0] sel_cnt;
    logic sel_run;
    logic [15:0] rep_cnt;
    logic rep_run;
    logic [15:0] bab_cnt;
    logic bab_run;
    logic bab_done;
    logic [7:0] msg_cnt;
    logic [7:0] cur_trib;
    logic [7:0] bab_addr;
    logic recover;
    logic bab_resp;
    logic [DIV_W-1:0] div;
    logic tick;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } state_t;

  state_t r_reg;
  state_t r_next;

  logic reply_mode;
  logic sel_mode;
  logic ctrl_mp;
  logic rate_bad;
  logic ap_take;
  logic rx_good;

  always_comb
  begin
    reply_mode = (r_reg.mode == MODE_FDX_P2P); // R01
    sel_mode = !reply_mode && !(r_reg.trib && r_reg.mode != MODE_HDX_P2P); // R01
    ctrl_mp = !r_reg.trib && (r_reg.mode == MODE_FDX_CTRL || r_reg.mode == MODE_HDX_CTRL); // R13
    rx_good = rx_msg_done && rx_msg_valid;
    ap_take = hsel && hready && htrans[1];
    // Speed range bounds the programmed line rate
    if (r_reg.speed_high)
      rate_bad = (r_reg.rate_kbps < RATE_SPLIT_KBPS) || (r_reg.rate_kbps > RATE_MAX_KBPS); // R08
    else
      rate_bad = (r_reg.rate_kbps >= RATE_SPLIT_KBPS); // R08
  end

  always_comb
  begin
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    ev = '0;
    clr = '0;
    r_next = r_reg;
    r_next.recover = 1'b0;
    r_next.bab_resp = 1'b0;
    r_next.tick = 1'b0;

    // Common millisecond time base
    if (r_reg.div == DIV_W'(TICK_CYCLES_P - 1)) // R19
    begin
      r_next.div = '0;
      r_next.tick = 1'b1;
    end
    else
      r_next.div = r_reg.div + 1'b1;

    if (rx_msg_done)
      r_next.cur_trib = rx_msg_addr;

    if (reply_mode)
    begin
      // No sharing in this mode, line always ours
      r_next.link = LS_OWN;
      r_next.sel_run = 1'b0;
      r_next.msg_cnt = '0;
      if (r_reg.rep_run && r_reg.tick)
      begin
        if (r_reg.rep_cnt <= 16'h0001) // R10
        begin
          r_next.rep_run = 1'b0;
          r_next.recover = 1'b1;
          ev[EV_REPLY] = 1'b1;
        end
        else
          r_next.rep_cnt = r_reg.rep_cnt - 1'b1; // R19
      end
      if (tx_msg_done && !r_reg.rep_run) // R10
      begin
        r_next.rep_run = 1'b1;
        r_next.rep_cnt = r_reg.sel_period;
      end
      if (ack_rx)
        r_next.rep_run = 1'b0; // R10
    end
    else
    begin
      r_next.rep_run = 1'b0;
      case (r_reg.link)
        LS_OWN:
        begin
          if (tx_msg_done && force_sel)
            ev[EV_FORCE] = 1'b1; // R17
          if (tx_msg_done && (tx_msg_sel || force_sel)) // R04
          begin
            // Timer starts at hand-off; short messages may still sit in the buffer
            r_next.link = LS_REMOTE;
            r_next.sel_run = sel_mode; // R05 R12
            r_next.sel_cnt = r_reg.sel_period;
            r_next.msg_cnt = '0;
          end
          else if (tx_msg_done)
            r_next.msg_cnt = r_reg.msg_cnt + 1'b1; // R17
        end
        LS_REMOTE:
        begin
          if (r_reg.sel_run && r_reg.tick)
            r_next.sel_cnt = r_reg.sel_cnt - 1'b1; // R19
          if (rx_good && rx_msg_sel) // R03
          begin
            r_next.link = LS_OWN;
            r_next.sel_run = 1'b0;
          end
          else if (rx_good)
            r_next.sel_cnt = r_reg.sel_period; // R05
          else if (r_reg.sel_run && r_reg.tick && r_reg.sel_cnt <= 16'h0001) // R06
          begin
            r_next.link = LS_OWN;
            r_next.sel_run = 1'b0;
            ev[EV_SEL] = 1'b1;
          end
        end
        default:
          r_next.link = LS_OWN;
      endcase
    end

    // Babbling tributary watch; report only, line left alone
    if (!ctrl_mp || !remote_carrier) // R13 R14
    begin
      r_next.bab_run = 1'b0;
      r_next.bab_done = 1'b0;
    end
    else if (!r_reg.bab_run && !r_reg.bab_done)
    begin
      r_next.bab_run = 1'b1;
      r_next.bab_cnt = r_reg.bab_period;
    end
    else if (r_reg.bab_run && r_reg.tick)
    begin
      if (r_reg.bab_cnt <= 16'h0001) // R14
      begin
        r_next.bab_run = 1'b0;
        r_next.bab_done = 1'b1;
        r_next.bab_resp = 1'b1; // R15 R16
        r_next.bab_addr = r_reg.cur_trib; // R15
        ev[EV_BABBLE] = 1'b1;
      end
      else
        r_next.bab_cnt = r_reg.bab_cnt - 1'b1; // R19
    end

    ev[EV_RATE] = rate_bad; // R08
    r_next.sync_cnt = r_reg.sync_wr ? r_reg.sync_set : (r_reg.speed_high ? SYNC_HIGH : SYNC_LOW); // R07

    // Bus data phase write
    if (r_reg.ap_wr)
    begin
      case (r_reg.ap_addr)
        ADDR_CTRL:
        begin
          r_next.mode = mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
          r_next.speed_high = hwdata[CTRL_SPEED_BIT];
          r_next.trib = hwdata[CTRL_TRIB_BIT];
        end
        ADDR_SEL_PERIOD: r_next.sel_period = hwdata[15:0];
        ADDR_BAB_PERIOD: r_next.bab_period = hwdata[15:0];
        ADDR_MAX_TX: r_next.max_tx = hwdata[MAX_TX_LSB +: 8]; // R18
        ADDR_SYNC:
        begin
          r_next.sync_set = hwdata[15:0];
          r_next.sync_wr = 1'b1;
        end
        ADDR_RATE: r_next.rate_kbps = hwdata[15:0];
        ADDR_STATUS: clr = hwdata[NUM_EV-1:0];
        ADDR_MASK: r_next.mask = hwdata[NUM_EV-1:0];
        default: r_next.mask = r_reg.mask;
      endcase
    end
    // A new event wins over a clear in the same cycle
    r_next.status = (r_reg.status & ~clr) | ev;

    // Bus address phase; read data ready for the next cycle
    r_next.ap_wr = ap_take && hwrite;
    r_next.ap_addr = haddr[7:0];
    if (ap_take && !hwrite)
    begin
      case (haddr[7:0])
        ADDR_CTRL: r_next.rdata = {28'h0000000, r_reg.trib, r_reg.speed_high, r_reg.mode};
        ADDR_SEL_PERIOD: r_next.rdata = {16'h0000, r_reg.sel_period};
        ADDR_BAB_PERIOD: r_next.rdata = {16'h0000, r_reg.bab_period};
        ADDR_MAX_TX: r_next.rdata = {16'h0000, r_reg.max_tx, 8'h00};
        ADDR_SYNC: r_next.rdata = {16'h0000, r_reg.sync_cnt};
        ADDR_RATE: r_next.rdata = {16'h0000, r_reg.rate_kbps};
        ADDR_STATUS: r_next.rdata = {27'h0000000, r_reg.status};
        ADDR_MASK: r_next.rdata = {27'h0000000, r_reg.mask};
        ADDR_STATE: r_next.rdata = {r_reg.sel_cnt, r_reg.msg_cnt, 3'h0, r_reg.bab_run,
                                    r_reg.rep_run, r_reg.sel_run, r_reg.link, tx_permit};
        ADDR_BAB_REPORT: r_next.rdata = {16'h0000, BABBLE_CODE, r_reg.bab_addr};
        default: r_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
      r_reg.mode <= MODE_HDX_P2P;
      r_reg.sel_period <= SEL_DEFAULT_MS; // R11
      r_reg.bab_period <= BABBLE_DEFAULT_MS;
      r_reg.sync_cnt <= SYNC_LOW;
      r_reg.link <= LS_OWN;
    end
    else
      r_reg <= r_next;
  end

  assign tx_permit = (r_reg.link == LS_OWN); // R02
  // Zero means no limit on messages per interval
  assign force_sel = r_reg.trib && (r_reg.max_tx != 8'h00) && (r_reg.link == LS_OWN)
                     && (r_reg.msg_cnt + 8'h01 == r_reg.max_tx); // R17
  assign recover = r_reg.recover;
  assign babble_resp = r_reg.bab_resp;
  assign babble_code = BABBLE_CODE;
  assign babble_addr = r_reg.bab_addr;
  assign sync_count = r_reg.sync_cnt;
  assign irq = |(r_reg.status & r_reg.mask);
  assign hrdata = r_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Outside reply mode, ownership only returns through a select return or a timeout
  a_remote_silent: assert property (!tx_permit && !reply_mode && !rx_good // R02
    && !(r_reg.sel_run && r_reg.tick) |=> !tx_permit)
    else $error("line reclaimed without select return or timeout");
  a_reply_owns_line: assert property (reply_mode |=> tx_permit) // R01
    else $error("reply mode lost line ownership");
  a_sel_start: assert property (!reply_mode && tx_permit && tx_msg_done && tx_msg_sel // R04
    |=> !tx_permit && r_reg.sel_cnt == $past(r_reg.sel_period))
    else $error("select flag did not hand over line with fresh timer");
  a_sel_stop: assert property (!reply_mode && tx_permit && tx_msg_done && !tx_msg_sel // R04
    && !force_sel |=> tx_permit)
    else $error("line handed over without select flag");
  a_sel_reload: assert property (!tx_permit && !reply_mode && rx_good && !rx_msg_sel // R05
    |=> !tx_permit && r_reg.sel_cnt == $past(r_reg.sel_period))
    else $error("valid message did not restart selection timer");
  a_rx_sel_return: assert property (r_reg.link == LS_REMOTE && !reply_mode && rx_good // R03
    && rx_msg_sel |=> tx_permit && !r_reg.sel_run)
    else $error("received select flag did not return line");
  a_sel_timeout: assert property (r_reg.link == LS_REMOTE && !reply_mode && r_reg.sel_run // R06
    && r_reg.tick && r_reg.sel_cnt == 16'h0001 && !rx_good
    |=> tx_permit && r_reg.status[EV_SEL])
    else $error("selection timeout did not reclaim line");
  a_reply_start: assert property (reply_mode && tx_msg_done && !r_reg.rep_run && !ack_rx // R10
    |=> r_reg.rep_run && r_reg.rep_cnt == $past(r_reg.sel_period))
    else $error("reply timer not started by sent message");
  a_reply_recover: assert property (recover |-> $past(r_reg.rep_run && r_reg.tick) // R10
    && r_reg.status[EV_REPLY])
    else $error("recovery without reply timer expiry");
  a_babble_start: assert property (ctrl_mp && remote_carrier && !r_reg.bab_run // R14
    && !r_reg.bab_done |=> r_reg.bab_run && r_reg.bab_cnt == $past(r_reg.bab_period))
    else $error("babbling timer not started by carrier");
  // Report once; a new one needs the carrier to drop or the mode to leave multipoint control first
  a_babble_once: assert property (babble_resp |-> r_reg.bab_done ##1 !babble_resp [*3]) // R15
    else $error("babbling report repeated");
  a_babble_addr: assert property (babble_resp |-> babble_addr == $past(r_reg.cur_trib)) // R15
    else $error("babbling report names wrong tributary");
  a_force_limit: assert property (force_sel && tx_msg_done && !reply_mode // R17
    |=> !tx_permit && r_reg.status[EV_FORCE] && r_reg.msg_cnt == 8'h00)
    else $error("forced select did not end the interval");
  a_sync_default: assert property (!r_reg.sync_wr && !r_reg.ap_wr // R07
    |=> sync_count == ($past(r_reg.speed_high) ? SYNC_HIGH : SYNC_LOW))
    else $error("sync count default wrong");
endmodule : link_selection_timers

// File: src/link_timers_pkg.sv
// What this block does
// R01 - Full-duplex point-to-point uses the timer as reply timer; other modes as selection timer; a tributary in the two multipoint modes runs no timer
// R02 - Only one transmitter active at once; ours is off while remote owns line
// R03 - Received select flag grants transmit permission after reception completes
// R04 - Sending select flag stops transmission after the current message completes
// R05 - Selection timer starts on selecting remote, restarts on each valid message
// R06 - Selection timeout: keep the line and resume transmitting as if selected back
// R07 - Sync character count defaults to 10 at low speed, 15 at high
// R08 - Low speed range below 250K b/s; high range 250K to 1M b/s
// R09 - Host should program different timer values at the two half-duplex ends
// R10 - Reply timer bounds message-to-acknowledge wait; expiry starts error recovery
// R11 - Selection and reply timer default period is 3 seconds
// R12 - Timer may start before short messages (40 bytes or less) reach the line
// R13 - Babbling timer runs in half- and full-duplex multipoint control modes
// R14 - Measure continuous tributary transmit time against the babbling timeout
// R15 - Babbling timeout reports babbling code and offending tributary address to host
// R16 - After a babbling report, no further corrective action on the line
// R17 - Tributary counts sent messages; at the maximum it forces the select flag
// R18 - Maximum message count is the upper parameter byte; lower byte ignored
// R19 - All timers count down on a common millisecond tick, expiring once per start
package link_timers_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SEL_DEFAULT_S = 3;
  localparam logic [15:0] SEL_DEFAULT_MS = 16'(SEL_DEFAULT_S * 1000);
  localparam logic [15:0] BABBLE_DEFAULT_MS = 16'h1770;
  localparam logic [15:0] SYNC_LOW = 16'h000a;
  localparam logic [15:0] SYNC_HIGH = 16'h000f;
  localparam logic [15:0] RATE_SPLIT_KBPS = 16'h00fa;
  localparam logic [15:0] RATE_MAX_KBPS = 16'h03e8;
  localparam int SHORT_MSG_BYTES = 40;
  localparam logic [7:0] BABBLE_CODE = 8'h01;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_BAB_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_MAX_TX = 8'h0c;
  localparam logic [7:0] ADDR_SYNC = 8'h10;
  localparam logic [7:0] ADDR_RATE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_BAB_REPORT = 8'h24;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SPEED_BIT = 2;
  localparam int CTRL_TRIB_BIT = 3;
  localparam int MAX_TX_LSB = 8;
  // Status bits
  localparam int NUM_EV = 5;
  localparam int EV_SEL = 0;
  localparam int EV_REPLY = 1;
  localparam int EV_BABBLE = 2;
  localparam int EV_FORCE = 3;
  localparam int EV_RATE = 4;
  typedef enum logic [1:0] {
    MODE_FDX_P2P = 2'b00,
    MODE_FDX_CTRL = 2'b01,
    MODE_HDX_CTRL = 2'b10,
    MODE_HDX_P2P = 2'b11
  } mode_t;
  typedef enum logic [0:0] {
    LS_OWN = 1'b0,
    LS_REMOTE = 1'b1
  } link_t;
endpackage : link_timers_pkg

// File: test/remote_station.sv
module remote_station
(
  // Clock
  input wire logic hclk,
  // Line events toward the block
  output logic rx_msg_done,
  output logic rx_msg_valid,
  output logic rx_msg_sel,
  output logic [7:0] rx_msg_addr,
  output logic ack_rx,
  output logic remote_carrier
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_msg_done = 1'b0;
    rx_msg_valid = 1'b0;
    rx_msg_sel = 1'b0;
    rx_msg_addr = 8'h00;
    ack_rx = 1'b0;
    remote_carrier = 1'b0;
  end
  // One message after gap cycles; gap of one or more keeps drives off the edge
  task automatic send_msg(input logic ok, input logic sel, input logic [7:0] a, input int gap);
    repeat (gap) @(posedge hclk);
    rx_msg_done <= 1'b1;
    rx_msg_valid <= ok;
    rx_msg_sel <= sel;
    rx_msg_addr <= a;
    @(posedge hclk);
    // Qualifiers released: inverted so stale values cannot pass
    rx_msg_done <= 1'b0;
    rx_msg_valid <= ~ok;
    rx_msg_sel <= ~sel;
    rx_msg_addr <= ~a;
  endtask : send_msg
  // Carrier only while this station transmits
  task automatic carrier(input logic on);
    @(posedge hclk);
    remote_carrier <= on;
  endtask : carrier
  task automatic ack(input int gap);
    repeat (gap) @(posedge hclk);
    ack_rx <= 1'b1;
    @(posedge hclk);
    ack_rx <= 1'b0;
  endtask : ack
endmodule : remote_station

// File: test/tb_link_selection_timers.sv
module tb_link_selection_timers;
  timeunit 1ns;
  timeprecision 1ps;
  import link_timers_pkg::*;
  localparam int TK = 10;
  logic hclk, hresetn, hwrite, tx_msg_done, tx_msg_sel, hreadyout, hresp;
  logic tx_permit, force_sel, recover, babble_resp, irq;
  logic rx_msg_done, rx_msg_valid, rx_msg_sel, ack_rx, remote_carrier;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] babble_code, babble_addr, rx_msg_addr;
  logic [15:0] sync_count;
  int err_total, comparisons, n, k;
  link_selection_timers #(.TICK_CYCLES_P(TK)) i_link_selection_timers (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_msg_done(tx_msg_done),
    .tx_msg_sel(tx_msg_sel), .rx_msg_done(rx_msg_done), .rx_msg_valid(rx_msg_valid),
    .rx_msg_sel(rx_msg_sel), .rx_msg_addr(rx_msg_addr), .ack_rx(ack_rx),
    .remote_carrier(remote_carrier), .tx_permit(tx_permit), .force_sel(force_sel),
    .recover(recover), .babble_resp(babble_resp), .babble_code(babble_code),
    .babble_addr(babble_addr), .sync_count(sync_count), .irq(irq));
  remote_station i_remote_station (.hclk(hclk), .rx_msg_done(rx_msg_done),
    .rx_msg_valid(rx_msg_valid), .rx_msg_sel(rx_msg_sel), .rx_msg_addr(rx_msg_addr),
    .ack_rx(ack_rx), .remote_carrier(remote_carrier));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdy;
    int c;
    c = 0;
    do
    begin
      @(posedge hclk);
      c++;
    end
    while (hreadyout !== 1'b1 && c < 64);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
    #1;
  endtask : bus
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask : rdchk
  function automatic logic probe(input int s);
    case (s)
      0: return tx_permit;
      1: return recover;
      default: return babble_resp;
    endcase
  endfunction : probe
  // Bounded wait for an output; running out ends the run
  task automatic wait_sig(input int s, output int c);
    c = 0;
    do
    begin
      @(posedge hclk);
      #1;
      c++;
    end
    while (probe(s) !== 1'b1 && c < 300);
    if (c >= 300)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_sig
  task automatic send_tx(input logic sel);
    @(posedge hclk);
    tx_msg_done <= 1'b1;
    tx_msg_sel <= sel;
    @(posedge hclk);
    tx_msg_done <= 1'b0;
    tx_msg_sel <= 1'b0;
    #1;
  endtask : send_tx
  task automatic quiet(input int s, input string nm);
    k = 0;
    repeat (4 * TK)
    begin
      @(posedge hclk);
      #1;
      k += 32'(probe(s));
    end
    chk(nm, 32'(k), 32'h0);
  endtask : quiet
  task automatic t_reset;
    chk("tx_permit", 32'(tx_permit), 32'h1);
    chk("sync_count", 32'(sync_count), 32'(SYNC_LOW));
    chk("hresp", 32'(hresp), 32'h0);
    rdchk("ctrl", ADDR_CTRL, 32'h3, 32'hf);
    rdchk("sel_period", ADDR_SEL_PERIOD, 32'(SEL_DEFAULT_MS), 32'hffff);
    rdchk("unmapped", 8'h3c, 32'h0, 32'hffffffff);
  endtask : t_reset
  task automatic t_sel_timeout;
    // Short period here; the far end must be given a different one
    bus(1'b1, ADDR_SEL_PERIOD, 32'h3);
    send_tx(1'b1);
    chk("tx_permit", 32'(tx_permit), 32'h0);
    rdchk("state", ADDR_STATE, 32'h6, 32'h7);
    wait_sig(0, n);
    chk("expiry window", 32'(n >= 2 * TK - 2 && n <= 3 * TK + 2), 32'h1);
    rdchk("status sel", ADDR_STATUS, 32'h1, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    bus(1'b1, ADDR_MASK, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    bus(1'b1, ADDR_STATUS, 32'h1);
    chk("irq cleared", 32'(irq), 32'h0);
  endtask : t_sel_timeout
  task automatic t_sel_return;
    send_tx(1'b1);
    // Valid traffic spanning more than one period keeps the timer from expiring
    repeat (4) i_remote_station.send_msg(1'b1, 1'b0, 8'h01, 2 * TK);
    #1;
    chk("tx_permit held", 32'(tx_permit), 32'h0);
    i_remote_station.send_msg(1'b1, 1'b1, 8'h01, TK);
    #1;
    chk("tx_permit back", 32'(tx_permit), 32'h1);
    rdchk("status sel", ADDR_STATUS, 32'h0, 32'h1);
  endtask : t_sel_return
  task automatic t_reply;
    bus(1'b1, ADDR_CTRL, 32'h0);
    send_tx(1'b0);
    wait_sig(1, n);
    chk("reply window", 32'(n <= 3 * TK + 2), 32'h1);
    rdchk("status reply", ADDR_STATUS, 32'h2, 32'h3);
    bus(1'b1, ADDR_STATUS, 32'h3);
    send_tx(1'b0);
    i_remote_station.ack(TK);
    quiet(1, "recover after ack");
  endtask : t_reply
  task automatic t_babble;
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_BAB_PERIOD, 32'h2);
    i_remote_station.send_msg(1'b1, 1'b0, 8'h5a, 1);
    i_remote_station.carrier(1'b1);
    wait_sig(2, n);
    chk("babble window", 32'(n <= 2 * TK + 3), 32'h1);
    chk("babble_addr", 32'(babble_addr), 32'h5a);
    chk("babble_code", 32'(babble_code), 32'(BABBLE_CODE));
    chk("tx_permit", 32'(tx_permit), 32'h1);
    quiet(2, "babble repeat");
    rdchk("bab_report", ADDR_BAB_REPORT, {16'h0, BABBLE_CODE, 8'h5a}, 32'hffff);
    i_remote_station.carrier(1'b0);
  endtask : t_babble
  task automatic t_force;
    bus(1'b1, ADDR_CTRL, 32'hb);
    bus(1'b1, ADDR_MAX_TX, 32'h02a5);
    rdchk("max_tx", ADDR_MAX_TX, 32'h0200, 32'hffff);
    send_tx(1'b0);
    chk("force_sel", 32'(force_sel), 32'h1);
    send_tx(1'b0);
    chk("tx_permit", 32'(tx_permit), 32'h0);
    rdchk("status force", ADDR_STATUS, 32'h8, 32'h8);
    i_remote_station.send_msg(1'b1, 1'b1, 8'h01, 1);
    #1;
    chk("tx_permit back", 32'(tx_permit), 32'h1);
  endtask : t_force
  task automatic t_speed;
    bus(1'b1, ADDR_CTRL, 32'h3);
    bus(1'b1, ADDR_RATE, 32'h12c);
    rdchk("rate low", ADDR_STATUS, 32'h10, 32'h10);
    bus(1'b1, ADDR_CTRL, 32'h7);
    bus(1'b1, ADDR_STATUS, 32'h10);
    rdchk("rate high", ADDR_STATUS, 32'h0, 32'h10);
    chk("sync_count", 32'(sync_count), 32'(SYNC_HIGH));
    rdchk("sync", ADDR_SYNC, 32'(SYNC_HIGH), 32'hffff);
    bus(1'b1, ADDR_SYNC, 32'h14);
    rdchk("sync override", ADDR_SYNC, 32'h14, 32'hffff);
    chk("sync_count set", 32'(sync_count), 32'h14);
  endtask : t_speed
  // Mid-run reset must drop the override and every sticky event
  task automatic t_rerun;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_reset();
    rdchk("status", ADDR_STATUS, 32'h0, 32'h1f);
  endtask : t_rerun
  initial
  begin
    err_total = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    tx_msg_done = 1'b0;
    tx_msg_sel = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_reset();
    t_sel_timeout();
    t_sel_return();
    t_reply();
    t_babble();
    t_force();
    t_speed();
    t_rerun();
    report_and_stop();
  end
endmodule : tb_link_selection_timers
